// File: cfg_one_pkg.sv
// Constants and carrier types for the first configuration register bank
package cfg_one_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_PORTS = 2;
  localparam int NUM_IRQ = 7;
  localparam int NUM_BUS_PAIRS = 4;
  localparam int PAGE_W = 8;

  // Register offsets within the board window
  localparam logic [ADDR_W-1:0] PORT_A_CONFIG_ONE_OFS = 10'h101;
  localparam logic [ADDR_W-1:0] PORT_B_CONFIG_ONE_OFS = 10'h301;
  localparam logic [ADDR_W-1:0] PORT_A_PAGE_OFS = 10'h1c1;
  localparam logic [ADDR_W-1:0] PORT_B_PAGE_OFS = 10'h3c1;

  // Field positions inside a configuration write
  localparam int IRQ_SEL_MSB = 7;
  localparam int IRQ_SEL_LSB = 5;
  localparam int BUS_PAIR_MSB = 4;
  localparam int BUS_PAIR_LSB = 3;
  localparam int CARRY_BIT = 2;
  localparam int ROR_BIT = 1;
  localparam int DIR_BIT = 0;

  // Reset values
  localparam logic [2:0] IRQ_SEL_RST = 3'h0;
  localparam logic [1:0] BUS_PAIR_RST = 2'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic ROR_DISABLE_RST = 1'b1;
  localparam logic DIR_RST = 1'b0;
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;

  // Direction encoding
  localparam logic DIR_MEM_TO_GPIB = 1'b0;
  localparam logic DIR_GPIB_TO_MEM = 1'b1;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [2:0] irq_line_select;
    logic [1:0] bus_req_grant_pair;
    logic release_on_request_disable;
  } shared_cfg_t;

  typedef struct packed {
    logic carry_cycle_enable;
    logic dma_dir;
  } port_cfg_t;

endpackage : cfg_one_pkg

// File: dual_port_config_register_one.sv
// Board-wide and per-port first configuration register with status readback
`timescale 1ns/100ps
`default_nettype none

module dual_port_config_register_one
  import cfg_one_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire reg_req_t reg_req,
  output reg_rsp_t reg_rsp_ff,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] gpib_status,
  input wire logic ext_addr_mode,
  input wire logic [NUM_PORTS-1:0] port_irq_req,
  input wire logic [NUM_PORTS-1:0] port_bus_req,
  input wire logic [NUM_BUS_PAIRS-1:0] bus_grant_in,
  output logic [NUM_IRQ-1:0] irq_out_ff,
  output logic [NUM_BUS_PAIRS-1:0] bus_req_out_ff,
  output logic [NUM_BUS_PAIRS-1:0] bus_grant_out_ff,
  output logic bus_granted_ff,
  output logic [PAGE_W-1:0] sys_addr_hi_ff,
  output shared_cfg_t shared_cfg_ff,
  output port_cfg_t [NUM_PORTS-1:0] port_cfg_ff
);

  logic wr_cfg_a;
  logic wr_cfg_b;
  logic wr_cfg_any;
  logic wr_page;
  logic rd_cfg_a;
  logic rd_cfg_b;
  logic rd_page;
  logic [NUM_PORTS-1:0] wr_cfg_port;
  logic [PAGE_W-1:0] page_ff;
  logic [PAGE_W-1:0] nxt_page;
  shared_cfg_t nxt_shared;
  reg_rsp_t nxt_rsp;
  logic any_irq_req;
  logic any_bus_req;
  logic [NUM_IRQ-1:0] nxt_irq;
  logic [NUM_BUS_PAIRS-1:0] nxt_bus_req;
  logic [NUM_BUS_PAIRS-1:0] nxt_grant_out;
  logic nxt_granted;
  logic [PAGE_W-1:0] nxt_addr_hi;

  // Address decode
  always_comb
  begin
    wr_cfg_a = reg_req.sel && reg_req.wr && (reg_req.addr == PORT_A_CONFIG_ONE_OFS);
    wr_cfg_b = reg_req.sel && reg_req.wr && (reg_req.addr == PORT_B_CONFIG_ONE_OFS);
    rd_cfg_a = reg_req.sel && !reg_req.wr && (reg_req.addr == PORT_A_CONFIG_ONE_OFS);
    rd_cfg_b = reg_req.sel && !reg_req.wr && (reg_req.addr == PORT_B_CONFIG_ONE_OFS);
    wr_page = reg_req.sel && reg_req.wr
      && ((reg_req.addr == PORT_A_PAGE_OFS) || (reg_req.addr == PORT_B_PAGE_OFS));
    rd_page = reg_req.sel && !reg_req.wr
      && ((reg_req.addr == PORT_A_PAGE_OFS) || (reg_req.addr == PORT_B_PAGE_OFS));
    wr_cfg_any = wr_cfg_a || wr_cfg_b;
    wr_cfg_port = {wr_cfg_b, wr_cfg_a};
  end

  // Board-wide fields: one storage element whichever port writes
  always_comb
  begin
    nxt_shared = shared_cfg_ff;
    if (wr_cfg_any)
    begin
      nxt_shared.irq_line_select = reg_req.wdata[IRQ_SEL_MSB:IRQ_SEL_LSB];
      nxt_shared.bus_req_grant_pair = reg_req.wdata[BUS_PAIR_MSB:BUS_PAIR_LSB];
      nxt_shared.release_on_request_disable = reg_req.wdata[ROR_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      shared_cfg_ff.irq_line_select <= IRQ_SEL_RST;
      shared_cfg_ff.bus_req_grant_pair <= BUS_PAIR_RST;
      shared_cfg_ff.release_on_request_disable <= ROR_DISABLE_RST;
    end
    else
    begin
      shared_cfg_ff <= nxt_shared;
    end
  end

  // Port-local fields: separate copies, only the addressed port changes
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          port_cfg_ff[p].carry_cycle_enable <= CARRY_RST;
          port_cfg_ff[p].dma_dir <= DIR_RST;
        end
        else if (wr_cfg_port[p])
        begin
          port_cfg_ff[p].carry_cycle_enable <= reg_req.wdata[CARRY_BIT];
          port_cfg_ff[p].dma_dir <= reg_req.wdata[DIR_BIT];
        end
      end
    end
  endgenerate

  // Page register, one copy seen from both port windows
  always_comb
  begin
    nxt_page = page_ff;
    if (wr_page)
    begin
      nxt_page = reg_req.wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      page_ff <= PAGE_RST;
    end
    else
    begin
      page_ff <= nxt_page;
    end
  end

  // Upper address lines follow the page only in extended mode
  always_comb
  begin
    if (ext_addr_mode)
    begin
      nxt_addr_hi = page_ff;
    end
    else
    begin
      nxt_addr_hi = PAGE_RST;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sys_addr_hi_ff <= PAGE_RST;
    end
    else
    begin
      sys_addr_hi_ff <= nxt_addr_hi;
    end
  end

  // Read and write answer. Configuration is write-only, so its address
  // returns live status instead; unmapped reads return zero but still ack.
  always_comb
  begin
    nxt_rsp.ack = reg_req.sel;
    nxt_rsp.rdata = UNMAPPED_RDATA;
    if (rd_cfg_a)
    begin
      nxt_rsp.rdata = gpib_status[0];
    end
    else if (rd_cfg_b)
    begin
      nxt_rsp.rdata = gpib_status[1];
    end
    else if (rd_page)
    begin
      nxt_rsp.rdata = page_ff;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      reg_rsp_ff.ack <= 1'b0;
      reg_rsp_ff.rdata <= UNMAPPED_RDATA;
    end
    else
    begin
      reg_rsp_ff <= nxt_rsp;
    end
  end

  // Interrupt request lines
  always_comb
  begin
    any_irq_req = |port_irq_req;
  end

  genvar i;
  generate
    for (i = 0; i < NUM_IRQ; i++)
    begin : g_irq
      always_comb
      begin
        nxt_irq[i] = any_irq_req && (shared_cfg_ff.irq_line_select == 3'(i + 1));
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      irq_out_ff <= '0;
    end
    else
    begin
      irq_out_ff <= nxt_irq;
    end
  end

  // Bus request and grant daisy chain. Unselected pairs pass the grant
  // straight through; the selected pair keeps it while this board asks.
  always_comb
  begin
    any_bus_req = |port_bus_req;
  end

  genvar b;
  generate
    for (b = 0; b < NUM_BUS_PAIRS; b++)
    begin : g_bus
      always_comb
      begin
        if (shared_cfg_ff.bus_req_grant_pair == 2'(b))
        begin
          nxt_bus_req[b] = any_bus_req;
          nxt_grant_out[b] = bus_grant_in[b] && !any_bus_req;
        end
        else
        begin
          nxt_bus_req[b] = 1'b0;
          nxt_grant_out[b] = bus_grant_in[b];
        end
      end
    end
  endgenerate

  always_comb
  begin
    nxt_granted = any_bus_req && bus_grant_in[shared_cfg_ff.bus_req_grant_pair];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      bus_req_out_ff <= '0;
      bus_grant_out_ff <= '0;
      bus_granted_ff <= 1'b0;
    end
    else
    begin
      bus_req_out_ff <= nxt_bus_req;
      bus_grant_out_ff <= nxt_grant_out;
      bus_granted_ff <= nxt_granted;
    end
  end

endmodule : dual_port_config_register_one

`default_nettype wire

// File: cfg_one_sva.sv
// Port-level assertions for the first configuration register bank
`timescale 1ns/100ps
`default_nettype none
module cfg_one_sva
  import cfg_one_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire reg_req_t reg_req,
  input wire reg_rsp_t reg_rsp_ff,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] gpib_status,
  input wire logic ext_addr_mode,
  input wire logic [NUM_PORTS-1:0] port_irq_req,
  input wire logic [NUM_IRQ-1:0] irq_out_ff,
  input wire logic [PAGE_W-1:0] sys_addr_hi_ff,
  input wire shared_cfg_t shared_cfg_ff,
  input wire port_cfg_t [NUM_PORTS-1:0] port_cfg_ff
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_wr(logic [ADDR_W-1:0] ofs);
    reg_req.sel && reg_req.wr && reg_req.addr == ofs;
  endsequence
  sequence s_rd_a;
    reg_req.sel && !reg_req.wr && reg_req.addr == PORT_A_CONFIG_ONE_OFS;
  endsequence
  property p_ack;
    reg_req.sel |=> reg_rsp_ff.ack;
  endproperty
  property p_rd;
    s_rd_a |=> reg_rsp_ff.rdata == $past(gpib_status[0]);
  endproperty
  property p_shared;
    s_wr(PORT_B_CONFIG_ONE_OFS) |=> shared_cfg_ff == {$past(reg_req.wdata[7:3]),
      $past(reg_req.wdata[1])};
  endproperty
  property p_local;
    s_wr(PORT_A_CONFIG_ONE_OFS) |=> port_cfg_ff[1] == $past(port_cfg_ff[1]) &&
      port_cfg_ff[0] == {$past(reg_req.wdata[2]), $past(reg_req.wdata[0])};
  endproperty
  property p_irq_none;
    shared_cfg_ff.irq_line_select == 3'h0 |=> irq_out_ff == 7'h00;
  endproperty
  property p_irq_sel;
    (|port_irq_req) && shared_cfg_ff.irq_line_select != 3'h0 |=>
      irq_out_ff == 7'(7'h01 << ($past(shared_cfg_ff.irq_line_select) - 3'h1));
  endproperty
  property p_page;
    !ext_addr_mode |=> sys_addr_hi_ff == 8'h00;
  endproperty
  property p_rst;
    $rose(rst_b) |-> port_cfg_ff == '0 &&
      shared_cfg_ff == {IRQ_SEL_RST, BUS_PAIR_RST, ROR_DISABLE_RST};
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_rd: assert property (p_rd) else $error("status readback wrong");
  a_shared: assert property (p_shared) else $error("shared bits wrong");
  a_local: assert property (p_local) else $error("port bits wrong");
  a_irq_none: assert property (p_irq_none) else $error("irq driven");
  a_irq_sel: assert property (p_irq_sel) else $error("irq line wrong");
  a_page: assert property (p_page) else $error("page driven");
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : cfg_one_sva
bind dual_port_config_register_one cfg_one_sva chk_u (.clock, .rst_b, .reg_req, .reg_rsp_ff,
  .gpib_status, .ext_addr_mode, .port_irq_req, .irq_out_ff, .sys_addr_hi_ff, .shared_cfg_ff,
  .port_cfg_ff);
`default_nettype wire

// File: vme_host_model.sv
// Bus arbiter model that grants the requested pair
`timescale 1ns/100ps
`default_nettype none
module vme_host_model
  import cfg_one_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [NUM_BUS_PAIRS-1:0] bus_req_out_ff,
  output logic [NUM_BUS_PAIRS-1:0] bus_grant_in
);
  // Grants a cycle late, so the request is seen alone first
  always_ff @(posedge clock)
  begin
    bus_grant_in <= rst_b ? bus_req_out_ff : '0;
  end
endmodule : vme_host_model
`default_nettype wire

// File: tb_dual_port_config_register_one.sv
// Testbench for the first configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_dual_port_config_register_one;
  import cfg_one_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t reg_req = '0;
  reg_rsp_t reg_rsp_ff;
  logic [NUM_PORTS-1:0][DATA_W-1:0] gpib_status = '0;
  logic ext_addr_mode = 1'b0;
  logic [NUM_PORTS-1:0] port_irq_req = '0;
  logic [NUM_PORTS-1:0] port_bus_req = '0;
  logic [NUM_BUS_PAIRS-1:0] bus_grant_in;
  logic [NUM_IRQ-1:0] irq_out_ff;
  logic [NUM_BUS_PAIRS-1:0] bus_req_out_ff;
  logic [NUM_BUS_PAIRS-1:0] bus_grant_out_ff;
  logic bus_granted_ff;
  logic [PAGE_W-1:0] sys_addr_hi_ff;
  shared_cfg_t shared_cfg_ff;
  port_cfg_t [NUM_PORTS-1:0] port_cfg_ff;
  int bad_count = 0;
  int cmp_count = 0;
  always #5 clock = ~clock;
  dual_port_config_register_one dut_u (.clock, .rst_b, .reg_req, .reg_rsp_ff, .gpib_status,
    .ext_addr_mode, .port_irq_req, .port_bus_req, .bus_grant_in, .irq_out_ff, .bus_req_out_ff,
    .bus_grant_out_ff, .bus_granted_ff, .sys_addr_hi_ff, .shared_cfg_ff, .port_cfg_ff);
  vme_host_model host_u (.clock, .rst_b, .bus_req_out_ff, .bus_grant_in);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic access(logic wr, logic [ADDR_W-1:0] addr, logic [7:0] wd, output logic [7:0] rd);
    @(posedge clock);
    reg_req <= '{sel: 1'b1, wr: wr, addr: addr, wdata: wd};
    @(posedge clock);
    reg_req.sel <= 1'b0;
    #1;
    chk("ack", 8'h01, {7'h00, reg_rsp_ff.ack});
    rd = reg_rsp_ff.rdata;
  endtask : access
  task automatic rd_chk(logic [ADDR_W-1:0] addr, logic [7:0] exp);
    logic [7:0] r;
    access(1'b0, addr, 8'h00, r);
    chk("rdata", exp, r);
  endtask : rd_chk
  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("shared", {2'h0, IRQ_SEL_RST, BUS_PAIR_RST, ROR_DISABLE_RST}, {2'h0, shared_cfg_ff});
    chk("local", {4'h0, CARRY_RST, DIR_RST, CARRY_RST, DIR_RST}, {4'h0, port_cfg_ff});
  endtask : do_reset
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    summarize();
  end
  initial
  begin
    logic [7:0] d;
    do_reset();
    for (int k = 0; k < 8; k++)
    begin
      d = {k[2:0], k[1:0], k[0], ~k[0], k[1]};
      access(1'b1, PORT_A_CONFIG_ONE_OFS, d, d);
      d = {k[2:0], k[1:0], k[0], ~k[0], k[1]};
      chk("shared", {2'h0, d[7:3], d[1]}, {2'h0, shared_cfg_ff});
      chk("local_a", {6'h0, d[2], d[0]}, {6'h0, port_cfg_ff[0]});
      @(posedge clock);
      port_irq_req <= 2'(1 << k[0]);
      port_bus_req <= 2'b01;
      @(posedge clock);
      #1;
      chk("irq", k == 0 ? 8'h00 : 8'(1 << (k - 1)), {1'b0, irq_out_ff});
      chk("bus_req", 8'(1 << k[1:0]), {4'h0, bus_req_out_ff});
      repeat (2) @(posedge clock);
      #1;
      chk("granted", 8'h01, {7'h00, bus_granted_ff});
      chk("grant_out", 8'h00, {4'h0, bus_grant_out_ff});
      @(posedge clock);
      port_irq_req <= '0;
      port_bus_req <= '0;
      @(posedge clock);
      #1;
      chk("grant_pass", 8'(1 << k[1:0]), {4'h0, bus_grant_out_ff});
    end
    access(1'b1, PORT_A_CONFIG_ONE_OFS, 8'h00, d);
    access(1'b1, PORT_B_CONFIG_ONE_OFS, 8'h05, d);
    chk("local_a", 8'h00, {6'h0, port_cfg_ff[0]});
    chk("local_b", 8'h03, {6'h0, port_cfg_ff[1]});
    chk("shared", 8'h00, {2'h0, shared_cfg_ff});
    @(posedge clock);
    gpib_status <= {8'hc3, 8'h3c};
    ext_addr_mode <= 1'b1;
    rd_chk(PORT_A_CONFIG_ONE_OFS, 8'h3c);
    rd_chk(PORT_B_CONFIG_ONE_OFS, 8'hc3);
    rd_chk(10'h0ff, UNMAPPED_RDATA);
    access(1'b1, PORT_A_PAGE_OFS, 8'h5a, d);
    @(posedge clock);
    #1;
    chk("page", 8'h5a, sys_addr_hi_ff);
    rd_chk(PORT_B_PAGE_OFS, 8'h5a);
    do_reset();
    summarize();
  end
endmodule : tb_dual_port_config_register_one
`default_nettype wire
